/* File: rtl/hbridge_pkg.sv */
// Notes on behaviour
// - Supply low past filter turns every output off.
// - Outputs resume once supply stays good for filter time.
// - Supply high past filter sets overvoltage flag and condition.
// - Bridge-mode overvoltage drives both outputs high.
// - Overvoltage ends with supply; flag holds until cleared.
// - Thermal warning never stops outputs; flag is live.
// - Overtemperature past filter latches outputs off, sets flag.
// - Half-bridge follows inputs; bridge: b enables, a steers.
// - Drive needs enable high, disable low, enable bit.
// - Input-select bit swaps pins for virtual bits.
// - Undervoltage tri-states outputs; fault pin low until cleared.
// - Overvoltage latches fault pin; half-bridge outputs unchanged.
// - Short or overtemperature latch outputs off until cleared.
// - Bridge short stops both outputs; half-bridge only its own.
// - Pump undervoltage flag is live, changes no output.
// - Framing error only latches its flag; a one clears.
// - Per-output short flags latch; a one clears.
// - Supply faults act outside sleep, end with condition.
// - Disable fall, enable rise or a one clears absent faults.
// - Bridge-mode bit: one full bridge, zero half-bridge.
// - A set mask bit pulls the fault pin while flag active and awake.
package hbridge_pkg;

  // Clock rate
  localparam int CLK_MHZ = 200;

  // Filter times in nanoseconds, longest values
  localparam int UV_FILTER_NS = 10000;
  localparam int OV_FILTER_NS = 3000;
  localparam int OT_FILTER_NS = 11000;

  // Filter lengths in cycles, rounded down
  localparam int UV_FILTER_CYC = UV_FILTER_NS * CLK_MHZ / 1000;
  localparam int OV_FILTER_CYC = OV_FILTER_NS * CLK_MHZ / 1000;
  localparam int OT_FILTER_CYC = OT_FILTER_NS * CLK_MHZ / 1000;
  localparam int FILTER_W      = 12;

  // Status flag positions
  localparam int FLAG_W       = 12;
  localparam int BIT_OT       = 0;
  localparam int BIT_TW       = 1;
  localparam int BIT_OC       = 2;
  localparam int BIT_OL       = 3;
  localparam int BIT_SCG_A    = 4;
  localparam int BIT_SCG_B    = 5;
  localparam int BIT_SCP_A    = 6;
  localparam int BIT_SCP_B    = 7;
  localparam int BIT_OV       = 8;
  localparam int BIT_UV       = 9;
  localparam int BIT_PUMP_UV  = 10;
  localparam int BIT_FRAME    = 11;

  // Reset values
  localparam logic [11:0] FLAGS_RESET = 12'h000;
  localparam logic        UV_RESET    = 1'b1;

  // Synchronised pin vector positions
  localparam int SYNC_W       = 19;
  localparam int PIN_EN       = 0;
  localparam int PIN_EN_FLT   = 1;
  localparam int PIN_DIS      = 2;
  localparam int PIN_DIS_FLT  = 3;
  localparam int PIN_A        = 4;
  localparam int PIN_A_FLT    = 5;
  localparam int PIN_B        = 6;
  localparam int PIN_B_FLT    = 7;
  localparam int CMP_UV       = 8;
  localparam int CMP_OV       = 9;
  localparam int CMP_OT       = 10;
  localparam int CMP_TW       = 11;
  localparam int CMP_OC       = 12;
  localparam int CMP_OL       = 13;
  localparam int CMP_SCG_A    = 14;
  localparam int CMP_SCG_B    = 15;
  localparam int CMP_SCP_A    = 16;
  localparam int CMP_SCP_B    = 17;
  localparam int CMP_PUMP     = 18;

endpackage : hbridge_pkg

/* File: rtl/fault_filter.sv */
// Output rises once raw has held for LEN cycles
module fault_filter #(
  parameter int LEN = 2000,
  parameter int W   = 12
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clkEn,
  // Condition
  input  wire logic raw,
  output logic      filtered
);

  localparam logic [W-1:0] LAST = W'(LEN - 1);

  logic [W-1:0] count;

  // Any drop restarts the count, so glitches never accumulate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count    <= '0;
      filtered <= 1'b0;
    end else if (clkEn) begin
      if (!raw) begin
        count    <= '0;
        filtered <= 1'b0;
      end else if (count == LAST) begin
        filtered <= 1'b1;
      end else begin
        count <= count + W'(1);
      end
    end
  end

endmodule : fault_filter

/* File: rtl/hbridge_fault_supervisor.sv */
module hbridge_fault_supervisor (
  // Clock, reset, clock enable
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // Control pins with pad float indications
  input  wire logic        chipEnablePin,
  input  wire logic        chipEnableFloat,
  input  wire logic        outputDisablePin,
  input  wire logic        outputDisableFloat,
  input  wire logic        driveInputA,
  input  wire logic        driveInputAFloat,
  input  wire logic        driveInputB,
  input  wire logic        driveInputBFloat,
  // Raw analog comparator levels
  input  wire logic        supplyLowRaw,
  input  wire logic        supplyHighRaw,
  input  wire logic        overtempRaw,
  input  wire logic        warningTempRaw,
  input  wire logic        overcurrentRaw,
  input  wire logic        openLoadRaw,
  input  wire logic        shortGroundARaw,
  input  wire logic        shortGroundBRaw,
  input  wire logic        shortSupplyARaw,
  input  wire logic        shortSupplyBRaw,
  input  wire logic        pumpLowRaw,
  // Serial configuration
  input  wire logic        bridgeMode,
  input  wire logic        inputSelect,
  input  wire logic        virtualDriveA,
  input  wire logic        virtualDriveB,
  input  wire logic        outputEnableBit,
  input  wire logic        disableOvProtect,
  input  wire logic [11:0] faultMask,
  // Serial events
  input  wire logic        framingErrorPulse,
  input  wire logic        statusWrite,
  input  wire logic [11:0] statusWriteData,
  // Bridge outputs with drive enables
  output logic             bridgeOutputA,
  output logic             bridgeOutputAOe,
  output logic             bridgeOutputB,
  output logic             bridgeOutputBOe,
  // Open-drain fault pin
  output logic             faultFlagN,
  output logic             faultFlagNOe,
  // Status
  output logic [11:0]      statusFlags,
  output logic             undervoltageActive,
  output logic             overvoltageActive
);

  localparam int SW = hbridge_pkg::SYNC_W;

  // Safe levels for floating inputs
  function automatic logic [1:0] mapDrive(input logic bridge, input logic a,
                                          input logic aFlt, input logic b,
                                          input logic bFlt);
    logic [1:0] r;
    r = 2'b00;
    if (!bridge) begin
      r = {aFlt ? 1'b0 : a, bFlt ? 1'b0 : b};
    end else if (bFlt) begin
      r = 2'b11;
    end else if (aFlt) begin
      r = {~b, 1'b1};
    end else if (!b) begin
      r = 2'b11;
    end else begin
      r = a ? 2'b10 : 2'b01;
    end
    return r;
  endfunction : mapDrive

  // Two-flop synchroniser
  logic [SW-1:0] syncMeta;
  logic [SW-1:0] syncPins;
  logic [SW-1:0] rawVector;

  assign rawVector = {pumpLowRaw, shortSupplyBRaw, shortSupplyARaw, shortGroundBRaw,
                      shortGroundARaw, openLoadRaw, overcurrentRaw, warningTempRaw,
                      overtempRaw, supplyHighRaw, supplyLowRaw, driveInputBFloat,
                      driveInputB, driveInputAFloat, driveInputA, outputDisableFloat,
                      outputDisablePin, chipEnableFloat, chipEnablePin};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta <= '0;
      syncPins <= '0;
    end else if (clkEn) begin
      syncMeta <= rawVector;
      syncPins <= syncMeta;
    end
  end

  // Decoded pin levels
  logic enHigh;
  logic disOff;
  logic awake;
  logic pinA;
  logic pinB;
  logic fltA;
  logic fltB;

  assign enHigh = syncPins[hbridge_pkg::PIN_EN] & ~syncPins[hbridge_pkg::PIN_EN_FLT];
  assign disOff = ~syncPins[hbridge_pkg::PIN_DIS] & ~syncPins[hbridge_pkg::PIN_DIS_FLT];
  assign awake  = enHigh; // Low or floating enable means sleep

  // Virtual bits never float, so their float terms are tied off
  assign pinA = inputSelect ? virtualDriveA : syncPins[hbridge_pkg::PIN_A];
  assign pinB = inputSelect ? virtualDriveB : syncPins[hbridge_pkg::PIN_B];
  assign fltA = ~inputSelect & syncPins[hbridge_pkg::PIN_A_FLT];
  assign fltB = ~inputSelect & syncPins[hbridge_pkg::PIN_B_FLT];

  // Last pin levels for edges
  logic enPrev;
  logic disPrev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enPrev  <= 1'b0;
      disPrev <= 1'b0;
    end else if (clkEn) begin
      enPrev  <= enHigh;
      disPrev <= disOff;
    end
  end

  // Pin edges that clear faults
  logic pinClear;
  assign pinClear = (enHigh & ~enPrev) | (disOff & ~disPrev);

  // Supply and temperature filters
  logic uvEnter;
  logic uvLeave;
  logic ovFilt;
  logic otFilt;

  fault_filter #(.LEN(hbridge_pkg::UV_FILTER_CYC), .W(hbridge_pkg::FILTER_W)) uvEnterFilt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .raw     (syncPins[hbridge_pkg::CMP_UV]),
    .filtered(uvEnter)
  );

  fault_filter #(.LEN(hbridge_pkg::UV_FILTER_CYC), .W(hbridge_pkg::FILTER_W)) uvLeaveFilt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .raw     (~syncPins[hbridge_pkg::CMP_UV]),
    .filtered(uvLeave)
  );

  fault_filter #(.LEN(hbridge_pkg::OV_FILTER_CYC), .W(hbridge_pkg::FILTER_W)) ovFilter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .raw     (syncPins[hbridge_pkg::CMP_OV]),
    .filtered(ovFilt)
  );

  fault_filter #(.LEN(hbridge_pkg::OT_FILTER_CYC), .W(hbridge_pkg::FILTER_W)) otFilter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .raw     (syncPins[hbridge_pkg::CMP_OT]),
    .filtered(otFilt)
  );

  // Set from power-on; only a good supply clears it, so sleep cannot skip the filter
  logic uvState;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      uvState <= hbridge_pkg::UV_RESET;
    end else if (clkEn) begin
      if (uvEnter && awake) begin
        uvState <= 1'b1;
      end else if (uvLeave) begin
        uvState <= 1'b0;
      end
    end
  end

  // Overvoltage ends when its comparator drops
  logic ovState;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovState <= 1'b0;
    end else if (clkEn) begin
      if (ovFilt && awake) begin
        ovState <= 1'b1;
      end else if (!syncPins[hbridge_pkg::CMP_OV] || !awake) begin
        ovState <= 1'b0;
      end
    end
  end

  // Outputs permitted by pins, bit and supply
  logic driveAllowed;
  assign driveAllowed = enHigh & disOff & outputEnableBit & ~uvState;

  // Flag update
  logic [11:0] flagSet;
  logic [11:0] flagPresent;
  logic [11:0] flagClear;
  logic [11:0] next_flags;

  always_comb begin
    flagSet = '0;
    flagSet[hbridge_pkg::BIT_OT]      = otFilt & awake;
    flagSet[hbridge_pkg::BIT_TW]      = syncPins[hbridge_pkg::CMP_TW] & awake;
    flagSet[hbridge_pkg::BIT_OC]      = syncPins[hbridge_pkg::CMP_OC] & driveAllowed;
    flagSet[hbridge_pkg::BIT_OL]      = syncPins[hbridge_pkg::CMP_OL] & bridgeMode & awake;
    flagSet[hbridge_pkg::BIT_SCG_A]   = syncPins[hbridge_pkg::CMP_SCG_A] & driveAllowed;
    flagSet[hbridge_pkg::BIT_SCG_B]   = syncPins[hbridge_pkg::CMP_SCG_B] & driveAllowed;
    flagSet[hbridge_pkg::BIT_SCP_A]   = syncPins[hbridge_pkg::CMP_SCP_A] & driveAllowed;
    flagSet[hbridge_pkg::BIT_SCP_B]   = syncPins[hbridge_pkg::CMP_SCP_B] & driveAllowed;
    flagSet[hbridge_pkg::BIT_OV]      = ovState;
    flagSet[hbridge_pkg::BIT_UV]      = uvEnter & awake;
    flagSet[hbridge_pkg::BIT_PUMP_UV] = syncPins[hbridge_pkg::CMP_PUMP] & awake;
    flagSet[hbridge_pkg::BIT_FRAME]   = framingErrorPulse & awake;
    // A fault still present cannot be cleared
    flagPresent = '0;
    flagPresent[hbridge_pkg::BIT_OT]    = syncPins[hbridge_pkg::CMP_OT];
    flagPresent[hbridge_pkg::BIT_OC]    = syncPins[hbridge_pkg::CMP_OC];
    flagPresent[hbridge_pkg::BIT_OL]    = syncPins[hbridge_pkg::CMP_OL];
    flagPresent[hbridge_pkg::BIT_SCG_A] = syncPins[hbridge_pkg::CMP_SCG_A];
    flagPresent[hbridge_pkg::BIT_SCG_B] = syncPins[hbridge_pkg::CMP_SCG_B];
    flagPresent[hbridge_pkg::BIT_SCP_A] = syncPins[hbridge_pkg::CMP_SCP_A];
    flagPresent[hbridge_pkg::BIT_SCP_B] = syncPins[hbridge_pkg::CMP_SCP_B];
    flagPresent[hbridge_pkg::BIT_OV]    = ovState;
    flagPresent[hbridge_pkg::BIT_UV]    = uvState;
    // Pin edges clear all, a write only its ones
    if (pinClear) begin
      flagClear = '1;
    end else if (statusWrite) begin
      flagClear = statusWriteData;
    end else begin
      flagClear = '0;
    end
    // Live flags follow the condition; a set beats a clear
    next_flags = flagSet | (statusFlags & ~(flagClear & ~flagPresent));
    next_flags[hbridge_pkg::BIT_TW]      = flagSet[hbridge_pkg::BIT_TW];
    next_flags[hbridge_pkg::BIT_PUMP_UV] = flagSet[hbridge_pkg::BIT_PUMP_UV];
  end

  // Status register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      statusFlags <= hbridge_pkg::FLAGS_RESET;
    end else if (clkEn) begin
      statusFlags <= next_flags;
    end
  end

  // Shutdowns come from flags, so only a clear releases them
  logic otLatch;
  logic shortA;
  logic shortB;
  logic stopA;
  logic stopB;
  logic recirculate;
  logic [1:0] commanded;

  assign otLatch = statusFlags[hbridge_pkg::BIT_OT];
  assign shortA  = statusFlags[hbridge_pkg::BIT_SCG_A] | statusFlags[hbridge_pkg::BIT_SCP_A];
  assign shortB  = statusFlags[hbridge_pkg::BIT_SCG_B] | statusFlags[hbridge_pkg::BIT_SCP_B];

  // Bridge short stops both sides
  assign stopA = otLatch | shortA | (bridgeMode & shortB);
  assign stopB = otLatch | shortB | (bridgeMode & shortA);

  // Recirculate only in bridge mode with protection on
  assign recirculate = ovState & bridgeMode & ~disableOvProtect;

  assign commanded = mapDrive(bridgeMode, pinA, fltA, pinB, fltB);

  // Registered outputs; tri-state also drives level low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bridgeOutputA   <= 1'b0;
      bridgeOutputAOe <= 1'b0;
      bridgeOutputB   <= 1'b0;
      bridgeOutputBOe <= 1'b0;
    end else if (clkEn) begin
      bridgeOutputAOe <= driveAllowed & ~stopA;
      bridgeOutputBOe <= driveAllowed & ~stopB;
      if (recirculate) begin
        bridgeOutputA <= driveAllowed & ~stopA;
        bridgeOutputB <= driveAllowed & ~stopB;
      end else begin
        bridgeOutputA <= driveAllowed & ~stopA & commanded[1];
        bridgeOutputB <= driveAllowed & ~stopB & commanded[0];
      end
    end
  end

  // Fault pin: disable not low or masked flag; sleep leaves it high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      faultFlagNOe <= 1'b0;
    end else if (clkEn) begin
      faultFlagNOe <= awake & (~disOff | (|(statusFlags & faultMask)));
    end
  end

  assign faultFlagN = 1'b0; // Open drain only ever pulls low

  // Condition monitors
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      undervoltageActive <= hbridge_pkg::UV_RESET;
      overvoltageActive  <= 1'b0;
    end else if (clkEn) begin
      undervoltageActive <= uvState;
      overvoltageActive  <= ovState;
    end
  end

endmodule : hbridge_fault_supervisor

/* File: sim/hbridge_fault_supervisor_assertions.sv */
module hbridge_fault_supervisor_assertions (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Inputs watched
  input wire logic        supplyLowRaw,
  input wire logic        supplyHighRaw,
  input wire logic        warningTempRaw,
  input wire logic        bridgeMode,
  input wire logic        disableOvProtect,
  input wire logic [11:0] faultMask,
  input wire logic        framingErrorPulse,
  input wire logic        statusWrite,
  input wire logic [11:0] statusWriteData,
  // Outputs watched
  input wire logic        bridgeOutputA,
  input wire logic        bridgeOutputAOe,
  input wire logic        bridgeOutputB,
  input wire logic        bridgeOutputBOe,
  input wire logic        faultFlagNOe,
  input wire logic [11:0] statusFlags,
  input wire logic        undervoltageActive,
  input wire logic        overvoltageActive
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Raw supply run lengths; saturate so a long stretch cannot wrap
  logic [11:0] lowRun;
  logic [11:0] highRun;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lowRun  <= 12'h000;
      highRun <= 12'h000;
    end else begin
      lowRun  <= supplyLowRaw ? 12'h000 : lowRun + {11'h000, lowRun != 12'hfff};
      highRun <= !supplyHighRaw ? 12'h000 : highRun + {11'h000, highRun != 12'hfff};
    end
  end

  // Held bridge-mode overvoltage
  sequence ovBrake;
    overvoltageActive && bridgeMode && !disableOvProtect
    ##1 overvoltageActive && bridgeMode && !disableOvProtect && bridgeOutputAOe;
  endsequence
  // Framing report, no clear competing
  sequence frameSeen;
    framingErrorPulse && !statusWrite && bridgeOutputAOe;
  endsequence

  uv_tristate_a: assert property (
    undervoltageActive && $past(undervoltageActive) |-> !bridgeOutputAOe && !bridgeOutputBOe)
    else $error("Outputs driven during undervoltage");
  uv_filter_a: assert property (
    $fell(undervoltageActive) |-> lowRun >= hbridge_pkg::UV_FILTER_CYC)
    else $error("Early undervoltage release");
  ov_filter_a: assert property (
    $rose(overvoltageActive) |-> highRun >= hbridge_pkg::OV_FILTER_CYC)
    else $error("Early overvoltage");
  ov_release_a: assert property (
    !supplyHighRaw [*6] |-> !overvoltageActive)
    else $error("Overvoltage held");
  ov_brake_a: assert property (
    ovBrake |-> bridgeOutputA && bridgeOutputB)
    else $error("No recirculation");
  warn_live_a: assert property (
    statusFlags[hbridge_pkg::BIT_TW] |-> $past(warningTempRaw, 2) || $past(warningTempRaw, 3)
      || $past(warningTempRaw, 4))
    else $error("Stale warning flag");
  ot_latch_a: assert property (
    statusFlags[hbridge_pkg::BIT_OT] && $past(statusFlags[hbridge_pkg::BIT_OT])
      |-> !bridgeOutputAOe && !bridgeOutputBOe)
    else $error("Outputs driven with overtemperature latched");
  frame_set_a: assert property (
    frameSeen |-> ##[1:2] statusFlags[hbridge_pkg::BIT_FRAME])
    else $error("Framing flag not set");
  frame_clear_a: assert property (
    statusWrite && statusWriteData[hbridge_pkg::BIT_FRAME] && !framingErrorPulse
      && !$past(framingErrorPulse) |=> !statusFlags[hbridge_pkg::BIT_FRAME])
    else $error("Framing flag not cleared by write");
  fault_pin_a: assert property (
    $past(statusFlags[hbridge_pkg::BIT_OC] && faultMask[hbridge_pkg::BIT_OC] && bridgeOutputAOe)
      && bridgeOutputAOe |-> faultFlagNOe)
    else $error("Fault pin not pulled");
endmodule : hbridge_fault_supervisor_assertions

bind hbridge_fault_supervisor hbridge_fault_supervisor_assertions i_assertions (
  .clk_sys, .rst_n, .supplyLowRaw, .supplyHighRaw, .warningTempRaw, .bridgeMode,
  .disableOvProtect, .faultMask, .framingErrorPulse, .statusWrite, .statusWriteData,
  .bridgeOutputA, .bridgeOutputAOe, .bridgeOutputB, .bridgeOutputBOe, .faultFlagNOe,
  .statusFlags, .undervoltageActive, .overvoltageActive);

/* File: sim/mcu_model.sv */
module mcu_model (
  // Clock
  input  wire logic   clk_sys,
  // Control pins and float indications
  output logic        chipEnablePin,
  output logic        chipEnableFloat,
  output logic        outputDisablePin,
  output logic        outputDisableFloat,
  output logic        driveInputA,
  output logic        driveInputAFloat,
  output logic        driveInputB,
  output logic        driveInputBFloat,
  // Serial-side events, one cycle each
  output logic        framingErrorPulse,
  output logic        statusWrite,
  output logic [11:0] statusWriteData
);
  timeunit 1ns;
  timeprecision 1ps;

  // Awake, not disabled, drive inputs low
  initial begin
    {chipEnablePin, outputDisablePin} = 2'b10;
    {driveInputA, driveInputB} = 2'b00;
    {chipEnableFloat, outputDisableFloat, driveInputAFloat, driveInputBFloat} = 4'h0;
    framingErrorPulse = 1'b0;
    statusWrite = 1'b0;
    statusWriteData = 12'h000;
  end

  // A floating pin shows the inverse level
  task automatic pins(input logic [1:0] ed, input logic [1:0] ab, input logic [3:0] flt);
    @(negedge clk_sys);
    {chipEnableFloat, outputDisableFloat, driveInputAFloat, driveInputBFloat} = flt;
    {chipEnablePin, outputDisablePin} = ed ^ flt[3:2];
    {driveInputA, driveInputB} = ab ^ flt[1:0];
  endtask : pins

  // Ones in the data select the flags to clear
  task automatic clear(input logic [11:0] data);
    @(negedge clk_sys);
    statusWrite = 1'b1;
    statusWriteData = data;
    @(negedge clk_sys);
    statusWrite = 1'b0;
    statusWriteData = 12'h000;
  endtask : clear

  // One-cycle framing report
  task automatic frame;
    @(negedge clk_sys);
    framingErrorPulse = 1'b1;
    @(negedge clk_sys);
    framingErrorPulse = 1'b0;
  endtask : frame
endmodule : mcu_model

/* File: sim/hbridge_fault_supervisor_bench.sv */
module hbridge_fault_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UVC = hbridge_pkg::UV_FILTER_CYC;
  localparam int OVC = hbridge_pkg::OV_FILTER_CYC;
  localparam int OTC = hbridge_pkg::OT_FILTER_CYC;
  // Clock, reset and comparator levels; supply starts low
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        supplyLowRaw = 1'b1;
  logic        supplyHighRaw = 1'b0;
  logic        overtempRaw = 1'b0;
  logic        warningTempRaw = 1'b0;
  logic        overcurrentRaw = 1'b0;
  logic        openLoadRaw = 1'b0;
  logic [3:0]  shortRaw = 4'h0; // Ground a, ground b, supply a, supply b
  logic        pumpLowRaw = 1'b0;
  // Configuration bits
  logic        bridgeMode = 1'b1;
  logic        inputSelect = 1'b0;
  logic [1:0]  virtualDrive = 2'b00;
  logic        outputEnableBit = 1'b1;
  logic        disableOvProtect = 1'b0;
  logic [11:0] faultMask = 12'hfff;
  // Controller pins and design outputs
  wire logic   chipEnablePin, chipEnableFloat, outputDisablePin, outputDisableFloat;
  wire logic   driveInputA, driveInputAFloat, driveInputB, driveInputBFloat;
  wire logic   framingErrorPulse, statusWrite;
  wire logic [11:0] statusWriteData;
  logic        oeA, outA, oeB, outB, faultFlagNOe, undervoltageActive, overvoltageActive;
  logic [11:0] statusFlags;
  wire logic [11:0] outs = {8'h00, oeA, outA, oeB, outB};
  int          nMismatch = 0;
  int          nChecks = 0;
  int          cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  mcu_model i_mcu_model (
    .clk_sys, .chipEnablePin, .chipEnableFloat, .outputDisablePin, .outputDisableFloat,
    .driveInputA, .driveInputAFloat, .driveInputB, .driveInputBFloat,
    .framingErrorPulse, .statusWrite, .statusWriteData);

  hbridge_fault_supervisor i_hbridge_fault_supervisor (
    .clk_sys, .rst_n, .clkEn(1'b1), .chipEnablePin, .chipEnableFloat, .outputDisablePin,
    .outputDisableFloat, .driveInputA, .driveInputAFloat, .driveInputB, .driveInputBFloat,
    .supplyLowRaw, .supplyHighRaw, .overtempRaw, .warningTempRaw, .overcurrentRaw,
    .openLoadRaw, .shortGroundARaw(shortRaw[3]), .shortGroundBRaw(shortRaw[2]),
    .shortSupplyARaw(shortRaw[1]), .shortSupplyBRaw(shortRaw[0]), .pumpLowRaw, .bridgeMode,
    .inputSelect,
    .virtualDriveA(virtualDrive[1]), .virtualDriveB(virtualDrive[0]), .outputEnableBit,
    .disableOvProtect, .faultMask, .framingErrorPulse, .statusWrite, .statusWriteData,
    .bridgeOutputA(outA), .bridgeOutputAOe(oeA), .bridgeOutputB(outB), .bridgeOutputBOe(oeB),
    .faultFlagN(), .faultFlagNOe, .statusFlags, .undervoltageActive, .overvoltageActive);

  // Compare with case inequality so unknowns never match
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_cyc

  // Outputs, flags and fault pin together
  task automatic look(input logic [11:0] o, input logic [11:0] f, input logic fp);
    chk(outs, o);
    chk(statusFlags, f);
    chk({11'h000, faultFlagNOe}, {11'h000, fp});
  endtask : look

  // Expected {oeA, outA, oeB, outB} for clean inputs
  function automatic logic [11:0] drv(input logic br, input logic [1:0] ab);
    logic a;
    logic b;
    a = br ? (ab[0] ? ab[1] : 1'b1) : ab[1];
    b = br ? (ab[0] ? !ab[1] : 1'b1) : ab[0];
    return {8'h00, 1'b1, a, 1'b1, b};
  endfunction : drv

  task automatic step(input logic br, input logic [1:0] ab, input logic [3:0] flt,
                      input logic [11:0] o);
    bridgeMode = br;
    i_mcu_model.pins(2'b10, ab, flt);
    wait_cyc(6);
    chk(outs, o);
  endtask : step

  // Blocked outputs tri-state
  task automatic gate(input logic [1:0] ed, input logic [3:0] flt, input logic oeb,
                      input logic fp);
    i_mcu_model.pins(ed, 2'b11, flt);
    outputEnableBit = oeb;
    wait_cyc(6);
    look(12'h000, 12'h000, fp);
  endtask : gate

  task automatic ov_run(input logic br, input logic dov, input logic [1:0] ab,
                        input logic [11:0] o);
    disableOvProtect = dov;
    step(br, ab, 4'h0, drv(br, ab));
    supplyHighRaw = 1'b1;
    wait_cyc(OVC - 8);
    chk({11'h000, overvoltageActive}, 12'h000);
    wait_cyc(16);
    chk({11'h000, overvoltageActive}, 12'h001);
    look(o, 12'h100, 1'b1);
    i_mcu_model.clear(12'h100);
    wait_cyc(2);
    chk(statusFlags, 12'h100);
    supplyHighRaw = 1'b0;
    wait_cyc(8);
    look(drv(br, ab), 12'h100, 1'b1);
    i_mcu_model.clear(12'h100);
    wait_cyc(3);
    look(drv(br, ab), 12'h000, 1'b0);
  endtask : ov_run

  task automatic short_run(input logic br, input logic [3:0] sc, input logic [11:0] f,
                           input logic [11:0] o);
    step(br, 2'b11, 4'h0, drv(br, 2'b11));
    shortRaw = sc;
    wait_cyc(6);
    shortRaw = 4'h0;
    wait_cyc(6);
    look(o, f, 1'b1);
  endtask : short_run

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Run needs about 10400 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      nMismatch++;
      close_out();
    end
  end

  initial begin
    wait_cyc(10);
    rst_n = 1'b1;
    supplyLowRaw = 1'b0;
    wait_cyc(UVC - 8);
    chk({11'h000, undervoltageActive}, 12'h001);
    chk(outs, 12'h000);
    wait_cyc(16);
    chk({11'h000, undervoltageActive}, 12'h000);
    for (int m = 0; m < 8; m++) begin
      step(m[2], m[1:0], 4'h0, drv(m[2], m[1:0]));
    end
    inputSelect = 1'b1;
    for (int m = 0; m < 4; m++) begin
      virtualDrive = m[1:0];
      step(1'b1, ~m[1:0], 4'h0, drv(1'b1, m[1:0]));
    end
    inputSelect = 1'b0;
    step(1'b1, 2'b01, 4'h2, 12'h00b);
    step(1'b1, 2'b10, 4'h1, 12'h00f);
    step(1'b0, 2'b00, 4'h2, 12'h00a);
    gate(2'b11, 4'h0, 1'b1, 1'b1);
    gate(2'b10, 4'h4, 1'b1, 1'b1);
    gate(2'b00, 4'h0, 1'b1, 1'b0);
    gate(2'b10, 4'h8, 1'b1, 1'b0);
    gate(2'b10, 4'h0, 1'b0, 1'b0);
    outputEnableBit = 1'b1;
    step(1'b1, 2'b11, 4'h0, 12'h00e);
    warningTempRaw = 1'b1;
    wait_cyc(6);
    look(12'h00e, 12'h002, 1'b1);
    warningTempRaw = 1'b0;
    wait_cyc(6);
    look(12'h00e, 12'h000, 1'b0);
    {pumpLowRaw, openLoadRaw} = 2'b11;
    wait_cyc(6);
    look(12'h00e, 12'h408, 1'b1);
    {pumpLowRaw, openLoadRaw} = 2'b00;
    overcurrentRaw = 1'b1;
    wait_cyc(6);
    overcurrentRaw = 1'b0;
    wait_cyc(6);
    look(12'h00e, 12'h00c, 1'b1);
    i_mcu_model.frame();
    wait_cyc(3);
    i_mcu_model.clear(12'h00c);
    wait_cyc(3);
    look(12'h00e, 12'h800, 1'b1);
    i_mcu_model.clear(12'h800);
    wait_cyc(3);
    look(12'h00e, 12'h000, 1'b0);
    ov_run(1'b1, 1'b0, 2'b11, 12'h00f);
    ov_run(1'b0, 1'b0, 2'b10, 12'h00e);
    ov_run(1'b1, 1'b1, 2'b11, 12'h00e);
    step(1'b1, 2'b11, 4'h0, 12'h00e);
    overtempRaw = 1'b1;
    wait_cyc(OTC + 8);
    look(12'h000, 12'h001, 1'b1);
    overtempRaw = 1'b0;
    wait_cyc(6);
    look(12'h000, 12'h001, 1'b1);
    i_mcu_model.pins(2'b11, 2'b11, 4'h0);
    step(1'b1, 2'b11, 4'h0, 12'h00e);
    chk(statusFlags, 12'h000);
    short_run(1'b0, 4'h8, 12'h010, 12'h003);
    i_mcu_model.clear(12'h010);
    wait_cyc(4);
    look(12'h00f, 12'h000, 1'b0);
    short_run(1'b1, 4'h7, 12'h0e0, 12'h000);
    i_mcu_model.pins(2'b00, 2'b11, 4'h0);
    step(1'b1, 2'b11, 4'h0, 12'h00e);
    chk(statusFlags, 12'h000);
    supplyLowRaw = 1'b1;
    wait_cyc(UVC + 8);
    look(12'h000, 12'h200, 1'b1);
    supplyLowRaw = 1'b0;
    wait_cyc(UVC + 8);
    look(12'h00e, 12'h200, 1'b1);
    i_mcu_model.clear(12'h200);
    wait_cyc(3);
    look(12'h00e, 12'h000, 1'b0);
    close_out();
  end
endmodule : hbridge_fault_supervisor_bench
